// ### abb_pkg.sv
// package: constants, enums and helpers for the and / bit-clear /
// conditional-branch execute block.
// assumes one core clock and a data memory with a 12-bit address.
package abb_pkg;

    // ========================================================
    // widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned FADDR_W = 12;
    localparam int unsigned PC_W_DEF = 21;

    // ========================================================
    // opcode fields
    localparam logic [5:0] OPC_AND_FILE = 6'h05;   // 0001 01da
    localparam logic [3:0] OPC_BIT_CLR = 4'h9;     // 1001 bbba
    localparam logic [7:0] OPC_BR_CARRY = 8'he2;
    localparam logic [7:0] OPC_BR_NO_CARRY = 8'he3;
    localparam logic [7:0] OPC_BR_NO_OVF = 8'he5;
    localparam logic [7:0] OPC_BR_NEG = 8'he6;
    localparam logic [7:0] OPC_BR_NOT_NEG = 8'he7;
    localparam int unsigned DEST_BIT_POS = 9;
    localparam int unsigned ACCESS_BIT_POS = 8;
    localparam int unsigned BIT_SEL_LSB = 9;

    // ========================================================
    // status bit positions and access bank layout
    localparam int unsigned ST_C_POS = 0;
    localparam int unsigned ST_Z_POS = 2;
    localparam int unsigned ST_OV_POS = 3;
    localparam int unsigned ST_N_POS = 4;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

    // ========================================================
    // reset values and increments
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [7:0] BIT_ONE = 8'h01;

    // ========================================================
    // enumerations
    typedef enum logic [1:0] {
        OP_NONE   = 2'h0,
        OP_AND    = 2'h1,
        OP_BCLR   = 2'h2,
        OP_BRANCH = 2'h3
    } abb_op_t;

    typedef enum logic [2:0] {
        CND_CARRY    = 3'h0,
        CND_NO_CARRY = 3'h1,
        CND_NEG      = 3'h2,
        CND_NOT_NEG  = 3'h3,
        CND_NO_OVF   = 3'h4
    } abb_cond_t;

    typedef enum logic {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } abb_state_t;

    // full data address: access bank splits on bit 7 of f
    function automatic logic [11:0] abb_file_addr(
        input logic       use_bsr,
        input logic [3:0] bank_pointer_register,
        input logic [7:0] f
    );
        logic [3:0] bank;
        bank = use_bsr ? bank_pointer_register : (f[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK);
        return {bank, f};
    endfunction : abb_file_addr

endpackage : abb_pkg

// ### abb_dec_if.sv
// interface: decoded instruction fields between decoder and executor.
// assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface abb_dec_if;
    import abb_pkg::*;
    logic [15:0] instr;
    abb_op_t     op;
    abb_cond_t   cond;
    logic        dest_file;
    logic        use_bsr;
    logic [2:0]  bit_sel;
    logic [7:0]  faddr;
    logic [7:0]  offset;

    modport dec (input instr, output op, cond, dest_file, use_bsr,
                 output bit_sel, faddr, offset);
    modport exe (output instr, input op, cond, dest_file, use_bsr,
                 input bit_sel, faddr, offset);
endinterface : abb_dec_if

// ### abb_decoder.sv
// module: combinational decoder for the supported instruction words.
// assumes the executor drives the instruction word through the interface.
`timescale 1ns/1ps
module abb_decoder (
    // decoded fields
    abb_dec_if.dec dif
);
    import abb_pkg::*;

    // ========================================================
    // decode
    // opcode match and field split
    always_comb
    begin
        dif.op        = OP_NONE;
        dif.cond      = CND_CARRY;
        dif.dest_file = dif.instr[DEST_BIT_POS];
        dif.use_bsr   = dif.instr[ACCESS_BIT_POS];
        dif.bit_sel   = dif.instr[BIT_SEL_LSB +: 3];
        dif.faddr     = dif.instr[7:0];
        dif.offset    = dif.instr[7:0];
        // RULE1: and-with-file match
        if (dif.instr[15:10] == OPC_AND_FILE)
        begin
            dif.op = OP_AND;
        end
        // RULE10: bit-clear match
        else if (dif.instr[15:12] == OPC_BIT_CLR)
        begin
            dif.op = OP_BCLR;
        end
        else
        begin
            // RULE4: conditional branch codes
            case (dif.instr[15:8])
                OPC_BR_CARRY:
                begin
                    dif.op   = OP_BRANCH;
                    dif.cond = CND_CARRY;
                end
                OPC_BR_NO_CARRY:
                begin
                    dif.op   = OP_BRANCH;
                    dif.cond = CND_NO_CARRY;
                end
                OPC_BR_NEG:
                begin
                    dif.op   = OP_BRANCH;
                    dif.cond = CND_NEG;
                end
                OPC_BR_NOT_NEG:
                begin
                    dif.op   = OP_BRANCH;
                    dif.cond = CND_NOT_NEG;
                end
                OPC_BR_NO_OVF:
                begin
                    dif.op   = OP_BRANCH;
                    dif.cond = CND_NO_OVF;
                end
                default:
                begin
                    dif.op = OP_NONE;
                end
            endcase
        end
    end

endmodule : abb_decoder

// ### abb_exec_core.sv
// module: execute stage for and-with-file, bit-clear and the
// conditional relative branches; owns accumulator, status and pc.
// assumes data memory reads combinationally on the same clock and
// that every input is synchronous to clk_i.
`timescale 1ns/1ps

// Contract
// RULE1: and-with-file ands the accumulator with the file and sets only n, z.
// RULE2: destination bit 0 writes the accumulator, 1 writes the file.
// RULE3: access bit 0 uses the access bank, 1 uses the bank pointer.
// RULE4: code e2 is branch-if-carry, taken on carry set, flags untouched.
// RULE5: code e6 is branch-if-negative, taken on n set, flags untouched.
// RULE6: code e3 is branch-if-no-carry, taken on carry clear, flags kept.
// RULE7: code e7 is branch-if-not-negative, taken on n clear, flags kept.
// RULE8: branch-if-no-overflow is taken on ov clear, flags untouched.
// RULE9: a taken branch loads pc with pc plus 2 plus twice the offset.
// RULE10: bit-clear reads the file, clears bit b, writes back, flags kept.
// RULE11: bit-clear access bit 0 uses the access bank, 1 the pointer.
// RULE12: a taken branch costs two cycles, the second a no-op.
module abb_exec_core #(
    parameter int unsigned PC_W = abb_pkg::PC_W_DEF
) (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    // instruction stream
    input  wire logic [abb_pkg::INSTR_W-1:0]  instr_i,
    input  wire logic                         instr_valid_i,
    output logic                              instr_ready_o,
    output logic [PC_W-1:0]                   fetch_pc_o,
    // data memory
    output logic [abb_pkg::FADDR_W-1:0]       fmem_addr_o,
    input  wire logic [abb_pkg::DATA_W-1:0]   fmem_rdata_i,
    output logic                              fmem_we_o,
    output logic [abb_pkg::FADDR_W-1:0]       fmem_waddr_o,
    output logic [abb_pkg::DATA_W-1:0]        fmem_wdata_o,
    // bank pointer register value
    input  wire logic [3:0]                   bsr_i,
    // loads from the rest of the core
    input  wire logic                         acc_we_i,
    input  wire logic [abb_pkg::DATA_W-1:0]   acc_wdata_i,
    input  wire logic                         status_we_i,
    input  wire logic [4:0]                   status_wdata_i,
    // state and events
    output logic [abb_pkg::DATA_W-1:0]        accumulator_o,
    output logic [4:0]                        status_o,
    output logic                              branch_taken_o,
    output logic                              illegal_o
);
    import abb_pkg::*;

    // ========================================================
    // declarations
    abb_dec_if    dif ();
    abb_state_t   state_reg;
    abb_state_t   state_next;
    logic [7:0]   acc_reg;
    logic [4:0]   status_reg;
    logic [PC_W-1:0] pc_reg;
    logic         fire;
    logic         fire_and;
    logic         fire_bclr;
    logic         fire_br;
    logic         take;
    logic [7:0]   rdata_fwd;
    logic [7:0]   and_res;
    logic [7:0]   bclr_res;
    logic [PC_W-1:0] pc_plus2;
    logic [PC_W-1:0] br_target;
    logic         we_reg;
    logic [11:0]  waddr_reg;
    logic [7:0]   wdata_reg;
    logic         taken_reg;
    logic         illegal_reg;

    // ========================================================
    // decode
    assign dif.instr = instr_i;

    abb_decoder u_dec (
        .dif (dif)
    );

    // issue qualifiers
    assign instr_ready_o = (state_reg == ST_EXEC);
    assign fire      = instr_valid_i && instr_ready_o;
    assign fire_and  = fire && (dif.op == OP_AND);
    assign fire_bclr = fire && (dif.op == OP_BCLR);
    assign fire_br   = fire && (dif.op == OP_BRANCH);

    // ========================================================
    // data path
    // RULE3: bank select for the file operand
    // RULE11: same bank select serves bit-clear
    assign fmem_addr_o = abb_file_addr(dif.use_bsr, bsr_i, dif.faddr);

    // forward a write still in flight to a back-to-back read
    assign rdata_fwd = (we_reg && (waddr_reg == fmem_addr_o))
                     ? wdata_reg : fmem_rdata_i;

    // RULE1: bitwise and of accumulator and file
    assign and_res  = acc_reg & rdata_fwd;
    // RULE10: force the selected bit low
    assign bclr_res = rdata_fwd & ~(BIT_ONE << dif.bit_sel);

    // RULE9: sign-extended offset doubled, added to pc plus 2
    assign pc_plus2  = pc_reg + PC_W'(2);
    assign br_target = pc_plus2
                     + PC_W'({{(PC_W-9){dif.offset[7]}}, dif.offset, 1'b0});

    // branch condition evaluation
    always_comb
    begin
        case (dif.cond)
            // RULE4: carry set
            CND_CARRY:    take = status_reg[ST_C_POS];
            // RULE6: carry clear
            CND_NO_CARRY: take = !status_reg[ST_C_POS];
            // RULE5: negative set
            CND_NEG:      take = status_reg[ST_N_POS];
            // RULE7: negative clear
            CND_NOT_NEG:  take = !status_reg[ST_N_POS];
            // RULE8: overflow clear
            CND_NO_OVF:   take = !status_reg[ST_OV_POS];
            default:      take = 1'b0;
        endcase
    end

    // ========================================================
    // accumulator
    // RULE2: destination bit 0 lands in the accumulator
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            acc_reg <= ACC_RST;
        else if (fire_and && !dif.dest_file)
            acc_reg <= and_res;
        else if (acc_we_i)
            acc_reg <= acc_wdata_i;
    end

    // ========================================================
    // status: besides the status_we_i load only the and touches n and z; branches leave it
    // RULE1: n and z from the and result
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            status_reg <= STATUS_RST;
        else if (fire_and)
        begin
            status_reg[ST_N_POS] <= and_res[7];
            status_reg[ST_Z_POS] <= (and_res == 8'h00);
        end
        else if (status_we_i)
            status_reg <= status_wdata_i;
    end

    // ========================================================
    // data memory write port, registered
    // RULE2: destination bit 1 writes back to the file
    // RULE10: bit-clear always writes back
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            we_reg    <= 1'b0;
            waddr_reg <= 12'h000;
            wdata_reg <= 8'h00;
        end
        else
        begin
            we_reg <= (fire_and && dif.dest_file) || fire_bclr;
            if ((fire_and && dif.dest_file) || fire_bclr)
            begin
                waddr_reg <= fmem_addr_o;
                wdata_reg <= fire_bclr ? bclr_res : and_res;
            end
        end
    end

    // ========================================================
    // program counter
    // RULE9: taken branch loads the target
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pc_reg <= '0;
        else if (fire_br && take)
            pc_reg <= br_target;
        else if (fire)
            pc_reg <= pc_plus2;
    end

    // ========================================================
    // issue state machine
    // RULE12: taken branch inserts one no-op cycle
    always_comb
    begin
        case (state_reg)
            ST_EXEC:  state_next = (fire_br && take) ? ST_FLUSH : ST_EXEC;
            ST_FLUSH: state_next = ST_EXEC;
            default:  state_next = ST_EXEC;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_reg <= ST_EXEC;
        else
            state_reg <= state_next;
    end

    // ========================================================
    // event pulses
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            taken_reg   <= 1'b0;
            illegal_reg <= 1'b0;
        end
        else
        begin
            taken_reg   <= fire_br && take;
            illegal_reg <= fire && (dif.op == OP_NONE);
        end
    end

    // ========================================================
    // outputs
    assign fetch_pc_o     = pc_reg;
    assign fmem_we_o      = we_reg;
    assign fmem_waddr_o   = waddr_reg;
    assign fmem_wdata_o   = wdata_reg;
    assign accumulator_o  = acc_reg;
    assign status_o       = status_reg;
    assign branch_taken_o = taken_reg;
    assign illegal_o      = illegal_reg;

    // ========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // RULE2: accumulator result
    a_and_to_acc: assert property ( // RULE2
        fire_and && !dif.dest_file
        |=> acc_reg == ($past(acc_reg) & $past(rdata_fwd)))
        else $error("and result missing from accumulator");

    // RULE2: file write-back
    a_and_to_file: assert property ( // RULE2
        fire_and && dif.dest_file && !acc_we_i
        |=> fmem_we_o && fmem_wdata_o == $past(and_res)
            && acc_reg == $past(acc_reg)
            && fmem_waddr_o == $past(fmem_addr_o))
        else $error("and write-back to file wrong");

    // RULE1: only n and z change
    a_and_flags: assert property ( // RULE1
        fire_and
        |=> status_reg[ST_Z_POS] == ($past(and_res) == 8'h00)
            && status_reg[ST_N_POS] == $past(and_res[7])
            && status_reg[ST_C_POS] == $past(status_reg[ST_C_POS])
            && status_reg[ST_OV_POS] == $past(status_reg[ST_OV_POS]))
        else $error("and flag update wrong");

    // RULE3: access bank versus bank pointer
    a_bank_select: assert property ( // RULE3
        (fire_and || fire_bclr)
        |-> fmem_addr_o[11:8] == (dif.use_bsr ? bsr_i
            : (dif.faddr[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK)))
        else $error("bank selection wrong");

    // RULE4: carry conditions
    a_carry_cond: assert property ( // RULE4
        fire_br && (dif.cond == CND_CARRY || dif.cond == CND_NO_CARRY)
        |-> take == (status_reg[ST_C_POS] ^ (dif.cond == CND_NO_CARRY)))
        else $error("carry branch decision wrong");

    // RULE5: negative conditions
    a_neg_cond: assert property ( // RULE5
        fire_br && (dif.cond == CND_NEG || dif.cond == CND_NOT_NEG)
        |-> take == (status_reg[ST_N_POS] ^ (dif.cond == CND_NOT_NEG)))
        else $error("negative branch decision wrong");

    // RULE8: overflow clear condition
    a_nov_cond: assert property ( // RULE8
        fire_br && dif.cond == CND_NO_OVF
        |-> take == !status_reg[ST_OV_POS])
        else $error("no-overflow branch decision wrong");

    // RULE7: branches keep the flags
    a_branch_flags: assert property ( // RULE7
        fire_br && !status_we_i |=> $stable(status_reg))
        else $error("branch changed status");

    // RULE9: target address
    a_branch_target: assert property ( // RULE9
        fire_br && take
        |=> pc_reg == $past(pc_reg) + PC_W'(2)
            + PC_W'({{(PC_W-9){$past(instr_i[7])}},
                     $past(instr_i[7:0]), 1'b0}))
        else $error("branch target wrong");

    // RULE10: bit-clear write-back
    a_bclr_write: assert property ( // RULE10
        fire_bclr
        |=> fmem_we_o
            && fmem_wdata_o == ($past(rdata_fwd)
                & ~(BIT_ONE << $past(dif.bit_sel)))
            && ($past(status_we_i) || $stable(status_reg)))
        else $error("bit-clear write wrong");

    // RULE12: two cycles taken, one not taken
    a_branch_cycles: assert property ( // RULE12
        fire_br && take
        |=> !instr_ready_o ##1 instr_ready_o)
        else $error("taken branch cycle count wrong");

    a_nobranch_one: assert property ( // RULE12
        fire_br && !take |=> instr_ready_o && !branch_taken_o)
        else $error("untaken branch stalled");

    // main scenarios
    c_and_file: cover property (fire_and && dif.dest_file);
    c_and_acc:  cover property (fire_and && !dif.dest_file);
    c_bclr_bsr: cover property (fire_bclr && dif.use_bsr);
    c_br_taken: cover property (fire_br && take ##2 fire);

endmodule : abb_exec_core

// ### tb_top.sv
// testbench: drives the execute block directly and checks its results.
// assumes a 125 MHz core clock and data memory modelled in the bench.
`timescale 1ns/1ps
module tb_top;
    import abb_pkg::*;
    typedef struct packed {
        logic [20:0] pc;
        logic [7:0]  acc;
        logic [4:0]  st;
        logic        tk;
        logic        il;
    } abb_snap_t;
    // ========================================================
    // signals and model state
    logic        clk_i, sys_rst_i, instr_valid_i, instr_ready_o;
    logic [15:0] instr_i;
    logic [20:0] fetch_pc_o;
    logic [11:0] fmem_addr_o, fmem_waddr_o;
    logic [7:0]  fmem_rdata_i, fmem_wdata_o, acc_wdata_i, accumulator_o;
    logic        fmem_we_o, acc_we_i, status_we_i, branch_taken_o;
    logic        illegal_o, took_prev;
    logic [3:0]  bsr_i;
    logic [4:0]  status_wdata_i, status_o, m_st;
    logic [7:0]  m_acc, m_mem [4096], dut_mem [4096];
    logic [20:0] m_pc;
    abb_snap_t   snap_q [$];
    logic [19:0] wr_q [$];
    int          bad_count, samples_checked;
    logic [7:0]  br_codes [5] = '{8'he2, 8'he3, 8'he5, 8'he6, 8'he7};

    abb_exec_core u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
        .fetch_pc_o(fetch_pc_o), .fmem_addr_o(fmem_addr_o),
        .fmem_rdata_i(fmem_rdata_i), .fmem_we_o(fmem_we_o),
        .fmem_waddr_o(fmem_waddr_o), .fmem_wdata_o(fmem_wdata_o),
        .bsr_i(bsr_i), .acc_we_i(acc_we_i), .acc_wdata_i(acc_wdata_i),
        .status_we_i(status_we_i), .status_wdata_i(status_wdata_i),
        .accumulator_o(accumulator_o), .status_o(status_o),
        .branch_taken_o(branch_taken_o), .illegal_o(illegal_o)
    );
    // combinational data memory read
    assign fmem_rdata_i = dut_mem[fmem_addr_o];
    // clock generation
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ========================================================
    // compare and closing tasks
    task automatic check_val(input string nm, input logic [31:0] e,
                             input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check_val
    task automatic check_write(input logic [19:0] e, input logic [19:0] g);
        check_val("mem write", {12'h0, e}, {12'h0, g});
    endtask : check_write
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // ========================================================
    // monitor: pops the oldest note when a result appears
    always @(posedge clk_i)
    begin
        if (fmem_we_o === 1'b1)
        begin
            if (wr_q.size() == 0)
                check_val("unexpected write", 32'h0, 32'h1);
            else
                check_write(wr_q.pop_front(), {fmem_waddr_o, fmem_wdata_o});
            dut_mem[fmem_waddr_o] <= fmem_wdata_o;
        end
        if (took_prev === 1'b1)
        begin
            if (snap_q.size() == 0)
                check_val("unexpected issue", 32'h0, 32'h1);
            else
            begin
                check_val("pc", snap_q[0].pc, fetch_pc_o);
                check_val("acc", snap_q[0].acc, accumulator_o);
                check_val("status", snap_q[0].st, status_o);
                check_val("taken", snap_q[0].tk, branch_taken_o);
                check_val("illegal", snap_q[0].il, illegal_o);
                void'(snap_q.pop_front());
            end
        end
        took_prev <= !sys_rst_i && instr_valid_i && instr_ready_o;
    end
    // ========================================================
    // driver tasks
    task automatic idle(input int n);
        instr_valid_i = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle
    task automatic load(input logic [4:0] st, input logic [7:0] acc);
        status_we_i = 1'b1;
        status_wdata_i = st;
        acc_we_i = 1'b1;
        acc_wdata_i = acc;
        idle(1);
        status_we_i = 1'b0;
        acc_we_i = 1'b0;
        m_st = st;
        m_acc = acc;
    endtask : load
    task automatic issue(input logic [15:0] w);
        abb_snap_t   e;
        logic [7:0]  rd, res;
        logic [11:0] a;
        logic        tk;
        instr_i = w;
        instr_valid_i = 1'b1;
        tk = 1'b0;
        e.il = 1'b0;
        a = {(w[8] ? bsr_i : (w[7] ? 4'hf : 4'h0)), w[7:0]};
        rd = m_mem[a];
        #1;
        if (w[15:10] == 6'b000101)
        begin
            check_val("and addr", a, fmem_addr_o);
            res = m_acc & rd;
            m_st[ST_N_POS] = res[7];
            m_st[ST_Z_POS] = (res == 8'h00);
            if (w[9])
            begin
                wr_q.push_back({a, res});
                m_mem[a] = res;
            end
            else
                m_acc = res;
        end
        else if (w[15:12] == 4'b1001)
        begin
            check_val("clr addr", a, fmem_addr_o);
            res = rd & ~(8'h01 << w[11:9]);
            wr_q.push_back({a, res});
            m_mem[a] = res;
        end
        else if (w[15:8] inside {8'he2, 8'he3, 8'he5, 8'he6, 8'he7})
        begin
            case (w[15:8])
                8'he2: tk = m_st[ST_C_POS];
                8'he3: tk = !m_st[ST_C_POS];
                8'he5: tk = !m_st[ST_OV_POS];
                8'he6: tk = m_st[ST_N_POS];
                default: tk = !m_st[ST_N_POS];
            endcase
        end
        else
            e.il = 1'b1;
        // branch target is pc + 2 + twice the signed offset
        m_pc = m_pc + 21'd2 + (tk ? {{12{w[7]}}, w[7:0], 1'b0} : 21'd0);
        e.pc = m_pc;
        e.acc = m_acc;
        e.st = m_st;
        e.tk = tk;
        snap_q.push_back(e);
        @(posedge clk_i);
        #1;
        if (tk)
        begin
            // flush slot: offered word must be refused
            instr_i = 16'h0e55;
            check_val("ready flush", 32'h0, instr_ready_o);
            @(posedge clk_i);
            #1;
            check_val("ready after", 32'h1, instr_ready_o);
        end
    endtask : issue
    task automatic do_reset();
        sys_rst_i = 1'b1;
        idle(2);
        sys_rst_i = 1'b0;
        m_pc = 21'h0;
        m_acc = 8'h00;
        m_st = 5'h00;
        check_val("rst pc", 32'h0, fetch_pc_o);
        check_val("rst acc", 32'h0, accumulator_o);
        check_val("rst status", 32'h0, status_o);
        check_val("rst ready", 32'h1, instr_ready_o);
    endtask : do_reset
    // ========================================================
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
    // ========================================================
    // main sequence
    initial
    begin
        logic [7:0] f, n;
        bad_count = 0;
        samples_checked = 0;
        took_prev = 1'b0;
        instr_i = 16'h0;
        bsr_i = 4'h0;
        acc_we_i = 1'b0;
        acc_wdata_i = 8'h0;
        status_we_i = 1'b0;
        status_wdata_i = 5'h0;
        void'($urandom(32'hc7a2));
        for (int i = 0; i < 4096; i++)
        begin
            m_mem[i] = 8'($urandom);
            dut_mem[i] = m_mem[i];
        end
        #1;
        do_reset();
        // known example: acc 17 and file c2 gives 02 into acc
        load(5'h00, 8'h17);
        m_mem[12'h010] = 8'hc2;
        dut_mem[12'h010] = 8'hc2;
        issue(16'h1410);
        // every branch code under random flags and boundary offsets
        for (int i = 0; i < 60; i++)
        begin
            load(5'($urandom), 8'($urandom));
            n = (i % 3 == 0) ? 8'h80 : ((i % 3 == 1) ? 8'h7f : 8'($urandom));
            issue({br_codes[i % 5], n});
            issue({br_codes[(i + 2) % 5], 8'($urandom)});
        end
        // and-with-file and bit-clear back to back on close addresses
        for (int i = 0; i < 60; i++)
        begin
            bsr_i = ($urandom % 2) ? 4'hf : 4'($urandom);
            f = ($urandom % 2) ? 8'h85 : 8'($urandom);
            if (i % 2 == 0)
                issue({6'b000101, 2'($urandom), f});
            else
                issue({4'b1001, 3'($urandom), 1'($urandom), f});
        end
        // unsupported words advance the pc and pulse illegal only
        issue({8'he4, 8'($urandom)});
        issue({8'he1, 8'h10});
        idle(2);
        do_reset();
        issue(16'he201);
        idle(3);
        check_val("notes left", 32'h0, snap_q.size() + wr_q.size());
        finish_test();
    end
endmodule : tb_top
